// ===== sdadc_ctrl.sv
// digital control of the delta-sigma converter: registers, clocking, modes and result capture
`timescale 1ns/1ps
`include "sdadc_defines.svh"

module sdadc_ctrl
   import sdadc_pkg::*;
(
   input  wire logic        REF_CLK,            // system clock, 10 MHz
   input  wire logic        RST_N,              // asynchronous reset, active low
   input  wire logic [7:0]  REG_ADDR,           // register byte address
   input  wire logic [7:0]  REG_WDATA,          // write data
   input  wire logic        REG_WR,             // write strobe
   input  wire logic        REG_RD,             // read strobe
   output logic      [7:0]  REG_RDATA,          // read data, the cycle after the strobe
   input  wire logic        SRC_CLK_TICK,       // converter source clock level, from a pin
   input  wire logic        FILT_WORD_VALID,    // filter finished one word, from analog side
   input  wire logic [25:0] FILT_WORD,          // raw signed filter word before clamping
   output logic             MCLK_OUT,           // master converter clock level
   output logic             MOD_CLK_OUT,        // modulator clock level
   output logic             BANDGAP_EN,         // bandgap power
   output logic             AMP_EN,             // input amplifier power
   output logic             MOD_EN,             // modulator power
   output logic             TEMP_EN,            // temperature sensor power
   output logic             NEG_BUF_EN,         // negative reference buffer on
   output logic             NEG_BYPASS,         // negative reference bypass switch
   output logic             POS_BUF_EN,         // positive reference buffer on
   output logic             POS_BYPASS,         // positive reference bypass switch
   output logic             FILT_EN,            // decimation filter power
   output logic             FILT_RST,           // decimation filter held in reset
   output logic [15:0]      FILT_DECIM,         // modulator samples per output word
   output logic [1:0]       OP_MODE             // decoded operating mode
);
   // reset release synchroniser
   logic rst_s1_q, rst_n_q;
   // pin input synchronisers
   logic [1:0] tick_sync_q;
   logic [1:0] vld_sync_q;
   logic       tick_prev_q;
   logic       vld_prev_q;

   // state of the control block, apart from the synchronisers and the two dividers
   typedef struct packed {
      logic [2:0]  divsel;     // modulator divide select
      logic        negbuf;     // negative buffer enable
      logic        posbuf;     // positive buffer enable
      logic        hold;       // result hold
      logic        eoc;        // end of conversion flag
      logic [4:0]  srcdiv;     // source clock divide field
      logic [7:0]  trim;       // reserved trim register
      logic        off;        // power off
      logic        slp;        // sleep
      logic        frst;       // filter reset control
      logic        tempen;     // temperature sensor request
      logic [3:0]  oversampling_ratio;        // oversampling select
      logic [23:0] result;     // clamped result
      logic [7:0]  rdata;      // read data
      logic        started;    // filter reset pulse seen since power-up
      logic        frst_seen;  // filter reset went high
      logic [25:0] word_hold;  // filter word sampled with its synchronised valid
      logic        word_new;   // a word was captured in the last cycle
   } sdadc_st_t;

   sdadc_st_t s_q, s_d;
   sdadc_mode_t mode;
   logic        vld_rise;     // synchronised valid edge
   logic        word_done;    // one completed conversion, in this domain
   logic        src_tick;     // synchronised source edge
   logic [23:0] clamped;      // word after saturation

   sdadc_div_if mdiv ();      // source to master clock divider
   sdadc_div_if ndiv ();      // master to modulator clock divider

   // release the reset through two flip-flops
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // two flip-flops on the pin inputs, then edge detect on the second
   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tick_sync_q <= 2'h0;
         vld_sync_q  <= 2'h0;
         tick_prev_q <= 1'b0;
         vld_prev_q  <= 1'b0;
      end else begin
         tick_sync_q <= {tick_sync_q[0], SRC_CLK_TICK};
         vld_sync_q  <= {vld_sync_q[0], FILT_WORD_VALID};
         tick_prev_q <= tick_sync_q[1];
         vld_prev_q  <= vld_sync_q[1];
      end
   end
   assign src_tick  = tick_sync_q[1] & ~tick_prev_q;
   assign vld_rise  = vld_sync_q[1] & ~vld_prev_q;
   // completion counts the cycle after capture, so the clamp works on the new word
   assign word_done = s_q.word_new & (mode == SDADC_MODE_NORMAL) & s_q.started;

   // master clock: half period of field+1 ticks, all ones passes through
   assign mdiv.half_cnt = (s_q.srcdiv == `SDADC_CLKSRC_BYPASS) ? 8'h00 : {3'h0, s_q.srcdiv} + 8'h01;
   assign mdiv.tick_in  = src_tick;
   // modulator clock: half of 30 or 12 master ticks, reserved codes keep 30
   assign ndiv.half_cnt = (s_q.divsel == `SDADC_DIVSEL_12) ? (`SDADC_MOD_DIV_12 >> 1)
                                                           : (`SDADC_MOD_DIV_30 >> 1);
   assign ndiv.tick_in  = mdiv.tick_out;

   sdadc_clkdiv u_mclk_div (
      .clk   (REF_CLK),
      .rst_n (rst_n_q),
      .dv    (mdiv)
   );
   sdadc_clkdiv u_modclk_div (
      .clk   (REF_CLK),
      .rst_n (rst_n_q),
      .dv    (ndiv)
   );

   // operating mode decode with power-off taking priority
   always_comb begin
      if (s_q.off) begin
         mode = SDADC_MODE_POWERDOWN;
      end else if (s_q.slp) begin
         mode = SDADC_MODE_SLEEP;
      end else if (s_q.frst) begin
         mode = SDADC_MODE_RESET;
      end else begin
         mode = SDADC_MODE_NORMAL;
      end
   end

   // saturate the raw word to 24-bit two's complement
   always_comb begin
      if (!s_q.word_hold[25] && s_q.word_hold[24:23] != 2'h0) begin
         clamped = `SDADC_RES_MAX;
      end else if (s_q.word_hold[25] && s_q.word_hold[24:23] != 2'h3) begin
         clamped = `SDADC_RES_MIN;
      end else begin
         clamped = s_q.word_hold[23:0];
      end
   end

   // register writes, reads, flag and result update
   always_comb begin
      s_d = s_q;
      s_d.word_new = vld_rise;             // completion follows one cycle after capture
      if (vld_rise) begin
         s_d.word_hold = FILT_WORD;        // word is stable while valid is high
      end
      // filter reset low-high-low starts conversions
      if (s_q.off) begin
         s_d.started   = 1'b0;
         s_d.frst_seen = 1'b0;
      end else if (s_q.frst) begin
         s_d.frst_seen = 1'b1;
      end else if (s_q.frst_seen) begin
         s_d.started = 1'b1;
      end
      if (REG_WR) begin
         if (REG_ADDR == `SDADC_OFS_CTRL1) begin
            s_d.divsel = REG_WDATA[`SDADC_BIT_DIVSEL_HI:`SDADC_BIT_DIVSEL_LO];
            s_d.negbuf = REG_WDATA[`SDADC_BIT_NEGBUF];
            s_d.posbuf = REG_WDATA[`SDADC_BIT_POSBUF];
            s_d.hold   = REG_WDATA[`SDADC_BIT_HOLD];
            if (!REG_WDATA[`SDADC_BIT_EOC]) begin
               s_d.eoc = 1'b0;             // zero clears, one ignored
            end
         end else if (REG_ADDR == `SDADC_OFS_CLKSRC) begin
            s_d.srcdiv = REG_WDATA[4:0];
         end else if (REG_ADDR == `SDADC_OFS_TRIM) begin
            s_d.trim = REG_WDATA;          // software keeps the pattern
         end else if (REG_ADDR == `SDADC_OFS_CTRL0) begin
            s_d.off    = REG_WDATA[`SDADC_BIT_OFF];
            s_d.slp    = REG_WDATA[`SDADC_BIT_SLP];
            s_d.frst   = REG_WDATA[`SDADC_BIT_FRST];
            s_d.tempen = REG_WDATA[`SDADC_BIT_TEMPEN];
            s_d.oversampling_ratio    = REG_WDATA[`SDADC_OSR_HI:`SDADC_OSR_LO];
         end
      end
      // completion sets the flag and result unless held; set beats clear
      if (word_done && !s_q.hold) begin
         s_d.eoc    = 1'b1;
         s_d.result = clamped;
      end
      // read data, unimplemented bits zero
      s_d.rdata = 8'h00;
      if (REG_RD) begin
         if (REG_ADDR == `SDADC_OFS_CTRL1) begin
            s_d.rdata = {s_q.divsel, s_q.negbuf, s_q.posbuf, s_q.hold, s_q.eoc, 1'b0};
         end else if (REG_ADDR == `SDADC_OFS_CLKSRC) begin
            s_d.rdata = {3'h0, s_q.srcdiv};
         end else if (REG_ADDR == `SDADC_OFS_TRIM) begin
            s_d.rdata = s_q.trim;
         end else if (REG_ADDR == `SDADC_OFS_CTRL0) begin
            // filter reset and sensor request share their write bits with the ratio code
            s_d.rdata = {2'h0, s_q.off, s_q.slp, s_q.oversampling_ratio};
         end else if (REG_ADDR == `SDADC_OFS_RES_LO) begin
            s_d.rdata = s_q.result[7:0];
         end else if (REG_ADDR == `SDADC_OFS_RES_MID) begin
            s_d.rdata = s_q.result[15:8];
         end else if (REG_ADDR == `SDADC_OFS_RES_HI) begin
            s_d.rdata = s_q.result[23:16];
         end
      end
   end

   // register the state
   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         s_q        <= '0;
         s_q.trim   <= `SDADC_TRIM_RESET;
         s_q.off    <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // analog enables per mode
   always_comb begin
      BANDGAP_EN = (mode != SDADC_MODE_POWERDOWN);
      AMP_EN     = (mode != SDADC_MODE_POWERDOWN);
      MOD_EN     = (mode == SDADC_MODE_NORMAL) || (mode == SDADC_MODE_RESET);
      TEMP_EN    = MOD_EN && s_q.tempen;
      NEG_BUF_EN = MOD_EN && s_q.negbuf;
      POS_BUF_EN = MOD_EN && s_q.posbuf;
      NEG_BYPASS = !s_q.negbuf;
      POS_BYPASS = !s_q.posbuf;
      FILT_EN    = (mode != SDADC_MODE_POWERDOWN);
      FILT_RST   = (mode == SDADC_MODE_RESET);
   end

   // decimation length: 32768 halved per code step, reserved codes clamp to 128
   // word rate then equals master clock over divide times ratio
   always_comb begin
      if (s_q.oversampling_ratio > `SDADC_OSR_MAX_CODE) begin
         FILT_DECIM = 16'h0080;
      end else begin
         FILT_DECIM = 16'h8000 >> s_q.oversampling_ratio;
      end
   end

   assign REG_RDATA   = s_q.rdata;
   assign MCLK_OUT    = mdiv.clk_out;
   assign MOD_CLK_OUT = ndiv.clk_out;
   assign OP_MODE     = mode;

   // one completion that is not held
   sequence s_unheld_done;
      word_done && !s_q.hold;
   endsequence

   // held results neither change nor raise the flag
   a_hold_freezes: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
      (s_q.hold && $stable(s_q.hold)) |=> ($stable(s_q.result) && !$rose(s_q.eoc)))
      else $error("result or flag moved while held");
   a_eoc_set: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
      s_unheld_done |=> s_q.eoc)
      else $error("flag not set after completion");
   // an unheld completion loads the clamped word
   a_result_load: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
      s_unheld_done |=> s_q.result == $past(clamped))
      else $error("result not loaded after completion");
   a_eoc_no_sw_set: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
      (!s_q.eoc && !word_done) |=> !s_q.eoc)
      else $error("flag set without completion");
   a_power_off: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
      s_q.off |-> !(BANDGAP_EN || AMP_EN || MOD_EN || TEMP_EN || FILT_EN || NEG_BUF_EN))
      else $error("block powered in power-off");
   a_sleep_mode: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
      (!s_q.off && s_q.slp) |-> (BANDGAP_EN && AMP_EN && FILT_EN && !MOD_EN && !POS_BUF_EN))
      else $error("sleep enables wrong");
   a_reset_mode: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
      (!s_q.off && !s_q.slp && s_q.frst) |-> (MOD_EN && FILT_RST))
      else $error("reset mode enables wrong");
   // normal mode runs modulator and filter out of reset
   a_normal_mode: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
      (!s_q.off && !s_q.slp && !s_q.frst) |-> (MOD_EN && FILT_EN && !FILT_RST))
      else $error("normal mode enables wrong");
   a_unimpl_zero: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
      (REG_RD && REG_ADDR == `SDADC_OFS_CTRL1) |=> !REG_RDATA[0])
      else $error("unimplemented bit read as one");
   a_clamp_range: assert property (@(posedge REF_CLK) disable iff (!rst_n_q)
      (!s_q.word_hold[25] && s_q.word_hold[24]) |-> clamped == `SDADC_RES_MAX)
      else $error("over range not clamped");
endmodule : sdadc_ctrl

// ===== sdadc_defines.svh
// register offsets, field positions, reset values and timing for the converter control
`ifndef SDADC_DEFINES_SVH
`define SDADC_DEFINES_SVH

`define SDADC_OFS_CTRL1      8'h08
`define SDADC_OFS_CLKSRC     8'h09
`define SDADC_OFS_TRIM       8'h0A
`define SDADC_OFS_CTRL0      8'h0B
`define SDADC_OFS_RES_LO     8'h04
`define SDADC_OFS_RES_MID    8'h05
`define SDADC_OFS_RES_HI     8'h06

`define SDADC_CTRL1_RESET    8'h00
`define SDADC_CLKSRC_RESET   8'h00
`define SDADC_TRIM_RESET     8'hE4
`define SDADC_CTRL0_RESET    8'h20

`define SDADC_BIT_DIVSEL_HI  7
`define SDADC_BIT_DIVSEL_LO  5
`define SDADC_BIT_NEGBUF     4
`define SDADC_BIT_POSBUF     3
`define SDADC_BIT_HOLD       2
`define SDADC_BIT_EOC        1
`define SDADC_BIT_OFF        5
`define SDADC_BIT_SLP        4
`define SDADC_BIT_FRST       3
`define SDADC_BIT_TEMPEN     2
`define SDADC_OSR_HI         3
`define SDADC_OSR_LO         0

`define SDADC_DIVSEL_30      3'h0
`define SDADC_DIVSEL_12      3'h2
`define SDADC_MOD_DIV_30     8'h1E
`define SDADC_MOD_DIV_12     8'h0C
`define SDADC_CLKSRC_BYPASS  5'h1F
`define SDADC_OSR_MAX_CODE   4'h8
`define SDADC_OSR_LOG2_BASE  5'h0F
`define SDADC_RES_MAX        24'h7FFFFF
`define SDADC_RES_MIN        24'h800000

`endif

// ===== sdadc_pkg.sv
// types shared by the converter control modules
package sdadc_pkg;
   // operating modes decoded from power, sleep and filter reset
   typedef enum logic [1:0] {
      SDADC_MODE_NORMAL,
      SDADC_MODE_SLEEP,
      SDADC_MODE_POWERDOWN,
      SDADC_MODE_RESET
   } sdadc_mode_t;
endpackage : sdadc_pkg

// ===== sdadc_div_if.sv
// divider control and tick bundle between the top and the dividers
`timescale 1ns/1ps
interface sdadc_div_if;
   logic [7:0] half_cnt;   // half period in input ticks, 0 means pass through
   logic       tick_in;    // input clock edge event
   logic       tick_out;   // output clock rising edge event
   logic       clk_out;    // divided clock level
   modport ctl (output half_cnt, output tick_in, input tick_out, input clk_out);
   modport div (input half_cnt, input tick_in, output tick_out, output clk_out);
endinterface : sdadc_div_if

// ===== sdadc_clkdiv.sv
// glitch free programmable clock divider working on input ticks
`timescale 1ns/1ps
module sdadc_clkdiv
   import sdadc_pkg::*;
(
   input wire logic   clk,
   input wire logic   rst_n,
   sdadc_div_if.div   dv
);
   // whole state of the divider
   typedef struct packed {
      logic [7:0] cnt;      // ticks left in the current half period
      logic       lvl;      // divided clock level
      logic [7:0] half;     // setting in force, taken only at the end of a full period
      logic       rise;     // registered rising edge event
   } sdadc_div_st_t;

   sdadc_div_st_t s_q, s_d;

   // count ticks; a new setting only takes effect at a period boundary
   always_comb begin
      s_d      = s_q;
      s_d.rise = 1'b0;
      if (dv.tick_in) begin
         if (s_q.half == 8'h00) begin
            s_d.rise = 1'b1;              // pass through: every input tick
            s_d.lvl  = 1'b1;              // level high one cycle per tick so each edge shows
            s_d.half = dv.half_cnt;
            s_d.cnt  = 8'h01;
         end else if (s_q.cnt <= 8'h01) begin
            s_d.lvl = ~s_q.lvl;
            s_d.cnt = s_q.half;
            if (!s_q.lvl) begin
               s_d.rise = 1'b1;
            end else begin
               s_d.half = dv.half_cnt;    // swap only at the end of a full period
               s_d.cnt  = (dv.half_cnt == 8'h00) ? 8'h01 : dv.half_cnt;
            end
         end else begin
            s_d.cnt = s_q.cnt - 8'h01;
         end
      end else if (s_q.half == 8'h00) begin
         s_d.lvl = 1'b0;                  // pass through level drops between ticks
      end
   end

   // register the state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dv.tick_out = s_q.rise;
   assign dv.clk_out  = s_q.lvl;

   // a divided level never toggles before its half period has run out
   a_no_short_high: assert property (@(posedge clk) disable iff (!rst_n)
      (dv.tick_in && s_q.half != 8'h00 && s_q.cnt > 8'h01) |-> s_d.lvl == s_q.lvl)
      else $error("divider level changed before half period ended");
endmodule : sdadc_clkdiv

// ===== sdadc_analog_model.sv
// behavioural model of the modulator, reference and decimation filter side
`timescale 1ns/1ps
module sdadc_analog_model (
   input  wire logic        clk,         // system clock
   output logic             src_tick,    // converter source clock level
   output logic             word_valid,  // filter word done
   output logic [25:0]      word         // raw signed filter word
);
   logic [1:0] src_cnt;  // source phase, one period is four system cycles

   // quiet lines at time zero
   initial begin
      src_cnt    = 2'h0;
      src_tick   = 1'b0;
      word_valid = 1'b0;
      word       = 26'h0;
   end

   // source clock runs free from its pin
   always @(posedge clk) begin
      src_cnt  <= src_cnt + 2'h1;
      src_tick <= src_cnt[1];
   end

   // one word: stable while valid is high, then the lines show another pattern
   task automatic send(input logic [25:0] w, input int hi);
      @(posedge clk);
      word       <= w;
      word_valid <= 1'b1;
      repeat (hi) @(posedge clk);
      word_valid <= 1'b0;
      word       <= ~w;
      repeat (4) @(posedge clk); // valid stays low between words
   endtask : send
endmodule : sdadc_analog_model

// ===== sigma_delta_adc_control_tb_top.sv
// self-checking testbench of the converter control
`timescale 1ns/1ps
module sigma_delta_adc_control_tb_top;
   logic        clk = 1'b0;      // system clock
   logic        rst_n = 1'b0;    // reset, active low
   logic [7:0]  addr = 8'h00;    // register address
   logic [7:0]  wdata = 8'h00;   // write data
   logic        wr_s = 1'b0;     // write strobe
   logic        rd_s = 1'b0;     // read strobe
   logic [7:0]  rdata;           // read data
   logic        src, fv;         // source clock, word valid
   logic [25:0] fw;              // filter word
   logic        mclk, mod, bg, amp, men, temp, nbe, nby, pbe, pby, fen, frst;
   logic [15:0] decim;           // decimation ratio
   logic [1:0]  opm;             // operating mode
   int          errors = 0;      // mismatches
   int          num_checks = 0;  // comparisons
   logic [7:0]  d;               // random byte
   logic [25:0] w [3];           // words for the result table
   int          n;               // measured period
   logic [6:0]  fm;              // expected mode outputs
   logic [23:0] e;               // expected result

   always #50 clk = ~clk;

   sdadc_ctrl u_dut (.REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .SRC_CLK_TICK(src),
      .FILT_WORD_VALID(fv), .FILT_WORD(fw), .MCLK_OUT(mclk), .MOD_CLK_OUT(mod),
      .BANDGAP_EN(bg), .AMP_EN(amp), .MOD_EN(men), .TEMP_EN(temp), .NEG_BUF_EN(nbe),
      .NEG_BYPASS(nby), .POS_BUF_EN(pbe), .POS_BYPASS(pby), .FILT_EN(fen),
      .FILT_RST(frst), .FILT_DECIM(decim), .OP_MODE(opm));

   sdadc_analog_model u_ana (.clk(clk), .src_tick(src), .word_valid(fv), .word(fw));

   // verdict and end of run
   task automatic end_sim;
      if (errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   // compare seen against expected
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one write cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
      @(negedge clk); // outputs looked at once the write has settled
   endtask : wr

   // one read cycle, data looked at in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask : rdchk

   // cycles between the third and fourth rise of a divided clock
   task automatic per_of(input bit sel, output int cnt);
      logic p, c;
      int   r;
      r = 0;
      cnt = 0;
      p = 1'b1;
      while (r < 4 && cnt < 4000) begin
         @(posedge clk);
         c = sel ? mod : mclk;
         cnt++;
         if (c && !p) begin
            r++;
            if (r < 4) cnt = 0;
         end
         p = c;
      end
   endtask : per_of

   // expected {bandgap, amp, modulator, filter, buffer, mode}
   function automatic logic [6:0] f_mode(input logic o, input logic s, input logic r);
      if (o) return {5'b00000, 2'h2};
      if (s) return {5'b11010, 2'h1};
      return {5'b11111, r ? 2'h3 : 2'h0};
   endfunction : f_mode

   // expected 24-bit result after clamping
   function automatic logic [23:0] f_sat(input logic [25:0] v);
      if (!v[25] && v[24:23] != 2'b00) return 24'h7FFFFF;
      if (v[25] && v[24:23] != 2'b11) return 24'h800000;
      return v[23:0];
   endfunction : f_sat

   // expected samples per word
   function automatic logic [15:0] f_decim(input logic [3:0] c);
      return (c <= 4'h8) ? (16'h8000 >> c) : 16'h0080;
   endfunction : f_decim

   // hang guard
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      end_sim();
   end

   // main sequence
   initial begin
      void'($urandom(57));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdchk(8'h08, 8'h00);
      rdchk(8'h09, 8'h00);
      rdchk(8'h0A, 8'hE4);
      chk({bg, nby, opm, decim}, {1'b0, 1'b1, 2'h2, 16'h8000});
      wr(8'h0A, 8'hE7);
      rdchk(8'h0A, 8'hE7);
      wr(8'h30, 8'h5A);
      rdchk(8'h30, 8'h00);
      // every power, sleep and filter reset combination, both buffers and sensor asked for
      wr(8'h08, 8'h18);
      for (int m = 0; m < 8; m++) begin
         wr(8'h0B, {2'b00, m[2], m[1], m[0], 3'b100});
         fm = f_mode(m[2], m[1], m[0]);
         chk({bg, amp, men, fen, nbe, opm}, fm);
         chk({pbe, nby, pby}, {fm[2], 2'b00});
         chk(temp, !m[2] && !m[1]);
         if (!m[2] && !m[1]) chk(frst, m[0]);
      end
      // random control and source values in normal mode
      wr(8'h0B, 8'h00);
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         wr(8'h08, d & 8'hFD);
         rdchk(8'h08, d & 8'hF8 | d & 8'h04);
         chk({nbe, nby, pbe, pby}, {d[4], ~d[4], d[3], ~d[3]});
         chk({men, fen, frst}, 3'b110);
         wr(8'h09, d);
         rdchk(8'h09, {3'b000, d[4:0]});
      end
      for (int c = 0; c < 10; c++) begin
         wr(8'h0B, {4'h0, 4'(c)});
         chk(decim, f_decim(4'(c)));
      end
      // divided clocks, the first periods after a change are skipped
      wr(8'h0B, 8'h00);
      wr(8'h08, 8'h00);
      for (int k = 0; k < 3; k++) begin
         d = (k == 0) ? 8'h1F : (k == 1) ? 8'h00 : 8'h03;
         wr(8'h09, d);
         per_of(1'b0, n);
         chk(n, (d == 8'h1F) ? 4 : 8 * (d + 1));
      end
      wr(8'h09, 8'h1F);
      per_of(1'b1, n);
      chk(n, 120);
      wr(8'h08, 8'h40);
      per_of(1'b1, n);
      chk(n, 48);
      // start pulse, then words in range, above and below
      wr(8'h08, 8'h00);
      wr(8'h0B, 8'h08);
      wr(8'h0B, 8'h00);
      w[0] = {{2{d[7]}}, 24'($urandom)};
      w[0][25:23] = {3{w[0][23]}};
      w[1] = 26'h0FFFFFF;
      w[2] = 26'h3000000;
      for (int i = 0; i < 3; i++) begin
         u_ana.send(w[i], 6);
         rdchk(8'h08, 8'h02);
         wr(8'h08, 8'h04);
         e = f_sat(w[i]);
         rdchk(8'h04, e[7:0]);
         rdchk(8'h05, e[15:8]);
         rdchk(8'h06, e[23:16]);
         wr(8'h08, 8'h00);
      end
      // held result and flag, then writes of one and zero to the flag
      wr(8'h08, 8'h04);
      u_ana.send(26'h0000123, 9);
      rdchk(8'h08, 8'h04);
      rdchk(8'h04, 8'h00);
      wr(8'h08, 8'h02);
      rdchk(8'h08, 8'h00);
      u_ana.send(26'h0000123, 6);
      rdchk(8'h04, 8'h23);
      wr(8'h08, 8'h02);
      rdchk(8'h08, 8'h02);
      wr(8'h08, 8'h00);
      rdchk(8'h08, 8'h00);
      end_sim();
   end
endmodule : sigma_delta_adc_control_tb_top
